// ### core/b4sio_core.sv
/*
  Burst-of-four separate-I/O synchronous memory, device side.
  Assumes the controller drives the clock pins, strobes, address and write data
  synchronous to MCLK, holds them steady over each sampling edge, and sequences
  the DLL enable as required. Storage is flip-flops, so depth is kept small.
*/
`timescale 1ns/1ps
module b4sio_core #(
  parameter int DW = 18,
  parameter int LANES = 2,
  parameter int AW = 4,
  parameter int IMP_PERIOD = b4sio_pkg::IMP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Input and output clock pins
  input wire logic K,
  input wire logic K_N,
  input wire logic C,
  input wire logic C_N,
  // Command and address
  input wire logic READ_N,
  input wire logic WRITE_N,
  input wire logic [AW-1:0] LINE_INDEX,
  // Write data
  input wire logic [DW-1:0] D,
  input wire logic [LANES-1:0] LANE_MASK_N,
  // Read data
  output logic [DW-1:0] Q,
  output logic Q_OE_N,
  // Delay loop
  input wire logic DLL_ENABLE,
  output logic DLL_LOCKED,
  // Impedance control
  input wire logic IMPEDANCE_REF_WEAK,
  output logic [b4sio_pkg::IMP_W-1:0] DRV_SETTING
);
  import b4sio_pkg::*;

  localparam int LW = DW / LANES;
  localparam int DEPTH = 1 << AW;

  // Clock pin sampling
  logic k_q, kn_q, c_q, cn_q;
  logic k_rise, kb_rise, c_tied, ot_rise, oc_rise;

  // Command tracking
  b4sio_op_t prev_q, prev_d, op_now;
  logic r_take, w_take;

  // Write path and array
  logic [BEATS-1:0][DW-1:0] mem_q [DEPTH];
  logic [BEATS-1:0][DW-1:0] mem_d [DEPTH];
  logic w_arm_q, w_arm_d;
  logic [AW-1:0] w_arm_addr_q, w_arm_addr_d;
  logic w_act_q, w_act_d;
  logic [BEAT_W-1:0] w_beat_q, w_beat_d;
  logic [AW-1:0] w_addr_q, w_addr_d;
  logic w_commit;
  logic [BEAT_W-1:0] w_cbeat;
  logic [AW-1:0] w_caddr;

  // Read path
  logic r_arm_q, r_arm_d;
  logic [AW-1:0] r_arm_addr_q, r_arm_addr_d;
  logic r_act_q, r_act_d;
  logic [BEAT_W-1:0] r_beat_q, r_beat_d;
  logic [AW-1:0] r_addr_q, r_addr_d;
  logic [DW-1:0] q_q, q_d;
  logic drive_q, drive_d;

  // Pins are synchronous, so one register gives a clean edge detect
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      k_q <= 1'b0;
      kn_q <= 1'b0;
      c_q <= 1'b0;
      cn_q <= 1'b0;
    end else begin
      k_q <= K;
      kn_q <= K_N;
      c_q <= C;
      cn_q <= C_N;
    end
  end

  assign k_rise = K && !k_q;
  assign kb_rise = K_N && !kn_q;

  // Both output clocks high on two samples means they are strapped high
  assign c_tied = C && C_N && c_q && cn_q;
  assign ot_rise = c_tied ? k_rise : (C && !c_q);
  assign oc_rise = c_tied ? kb_rise : (C_N && !cn_q);

  // Command decode on the true clock rise only
  always_comb begin
    r_take = k_rise && !READ_N && (prev_q != B4SIO_READ);
    // A read that is not ignored wins over a write in the same cycle
    w_take = k_rise && !WRITE_N && !r_take && (prev_q != B4SIO_WRITE);
    unique case (1'b1)
      r_take: op_now = B4SIO_READ;
      w_take: op_now = B4SIO_WRITE;
      default: op_now = B4SIO_DESEL;
    endcase
    prev_d = k_rise ? op_now : prev_q;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_q <= B4SIO_DESEL;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Write path: every beat lands in the array as it arrives
  always_comb begin
    mem_d = mem_q;
    w_arm_d = w_arm_q;
    w_arm_addr_d = w_arm_addr_q;
    w_act_d = w_act_q;
    w_beat_d = w_beat_q;
    w_addr_d = w_addr_q;
    w_commit = 1'b0;
    w_cbeat = w_beat_q;
    w_caddr = w_addr_q;
    if (k_rise && w_arm_q) begin
      // First beat on the true rise after the command
      w_commit = 1'b1;
      w_cbeat = BEAT_FIRST;
      w_caddr = w_arm_addr_q;
      w_act_d = 1'b1;
      w_beat_d = BEAT_SECOND;
      w_addr_d = w_arm_addr_q;
      w_arm_d = 1'b0;
    end else if (w_act_q && (w_beat_q[0] ? kb_rise : k_rise)) begin
      // Beats alternate complement and true rises; the tail overlaps the next command
      w_commit = 1'b1;
      w_beat_d = w_beat_q + BEAT_SECOND;
      if (w_beat_q == BEAT_LAST) begin
        w_act_d = 1'b0;
      end
    end
    if (w_take) begin
      w_arm_d = 1'b1;
      w_arm_addr_d = LINE_INDEX;
    end
    if (w_commit) begin
      for (int l = 0; l < LANES; l++) begin
        // Mask sampled with this beat only; all-high on every beat stores nothing
        if (!LANE_MASK_N[l]) begin
          mem_d[w_caddr][w_cbeat][l*LW +: LW] = D[l*LW +: LW];
        end
      end
    end
  end

  // Array is left unreset; contents are undefined until written
  always_ff @(posedge MCLK) begin
    mem_q <= mem_d;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      w_arm_q <= 1'b0;
      w_arm_addr_q <= '0;
      w_act_q <= 1'b0;
      w_beat_q <= BEAT_FIRST;
      w_addr_q <= '0;
    end else begin
      w_arm_q <= w_arm_d;
      w_arm_addr_q <= w_arm_addr_d;
      w_act_q <= w_act_d;
      w_beat_q <= w_beat_d;
      w_addr_q <= w_addr_d;
    end
  end

  // Read path: each beat is fetched at its launch edge, after any
  // earlier write beat to the same slot, so pending writes read back new data
  always_comb begin
    r_arm_d = r_arm_q;
    r_arm_addr_d = r_arm_addr_q;
    r_act_d = r_act_q;
    r_beat_d = r_beat_q;
    r_addr_d = r_addr_q;
    q_d = q_q;
    drive_d = drive_q;
    if (ot_rise && r_arm_q) begin
      // Armed value from an earlier edge, so a same-cycle rise is not used
      q_d = mem_q[r_arm_addr_q][BEAT_FIRST];
      r_act_d = 1'b1;
      r_beat_d = BEAT_SECOND;
      r_addr_d = r_arm_addr_q;
      r_arm_d = 1'b0;
      drive_d = 1'b1;
    end else if (r_act_q && (r_beat_q[0] ? oc_rise : ot_rise)) begin
      q_d = mem_q[r_addr_q][r_beat_q];
      r_beat_d = r_beat_q + BEAT_SECOND;
      if (r_beat_q == BEAT_LAST) begin
        r_act_d = 1'b0;
      end
    end else if (!r_act_q && ot_rise) begin
      // No new burst at this output edge: float for this cycle
      drive_d = 1'b0;
    end
    if (r_take) begin
      r_arm_d = 1'b1;
      r_arm_addr_d = LINE_INDEX;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r_arm_q <= 1'b0;
      r_arm_addr_q <= '0;
      r_act_q <= 1'b0;
      r_beat_q <= BEAT_FIRST;
      r_addr_q <= '0;
      q_q <= '0;
      drive_q <= 1'b0;
    end else begin
      r_arm_q <= r_arm_d;
      r_arm_addr_q <= r_arm_addr_d;
      r_act_q <= r_act_d;
      r_beat_q <= r_beat_d;
      r_addr_q <= r_addr_d;
      q_q <= q_d;
      drive_q <= drive_d;
    end
  end

  assign Q = q_q;
  assign Q_OE_N = !drive_q;

  // Lock only reports timing; data still moves before lock
  b4sio_dll #(
    .LOCK_CYC(DLL_LOCK_CYC)
  ) u_dll (
    .clk(MCLK),
    .rst_n(RST_N),
    .enable(DLL_ENABLE),
    .k_edge(k_rise || kb_rise),
    .k_true_rise(k_rise),
    .locked(DLL_LOCKED)
  );

  b4sio_zq #(
    .PERIOD(IMP_PERIOD)
  ) u_zq (
    .clk(MCLK),
    .rst_n(RST_N),
    .too_weak(IMPEDANCE_REF_WEAK),
    .setting(DRV_SETTING)
  );
endmodule // b4sio_core

// ### core/b4sio_dll.sv
/*
  Lock tracker for the output delay loop.
  Assumes clock edges arrive as one-cycle pulses from the core's edge detector.
*/
`timescale 1ns/1ps
module b4sio_dll #(
  parameter int LOCK_CYC = b4sio_pkg::DLL_LOCK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Loop inputs
  input wire logic enable,
  input wire logic k_edge,
  input wire logic k_true_rise,
  // Status
  output logic locked
);
  import b4sio_pkg::*;
  logic [LOCK_W-1:0] lock_q, lock_d;
  logic [STATIC_W-1:0] static_q, static_d;
  logic halted;

  // Stalled clock or a low enable throws the lock away
  assign halted = !enable || (static_q >= STATIC_W'(K_STATIC_CYC));

  always_comb begin
    static_d = static_q;
    lock_d = lock_q;
    if (k_edge) begin
      static_d = '0;
    end else if (static_q < STATIC_W'(K_STATIC_CYC)) begin
      static_d = static_q + STATIC_W'(1);
    end
    if (halted) begin
      lock_d = '0;
    end else if (k_true_rise && lock_q < LOCK_W'(LOCK_CYC)) begin
      lock_d = lock_q + LOCK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      static_q <= '0;
      lock_q <= '0;
    end else begin
      static_q <= static_d;
      lock_q <= lock_d;
    end
  end

  assign locked = (lock_q == LOCK_W'(LOCK_CYC)) && !halted;
endmodule // b4sio_dll

// ### core/b4sio_pkg.sv
/*
  Shared constants and types of the burst-of-four separate-I/O memory core.
  Assumes one 100 MHz clock; all pin inputs arrive synchronous to it.
*/
package b4sio_pkg;
  localparam int BEATS = 4;
  localparam int BEAT_W = 2;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_SECOND = 2'h1;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int K_STATIC_NS = 30;
  localparam int K_STATIC_CYC = (K_STATIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CYC = 1024;
  localparam int LOCK_W = 11;
  localparam int STATIC_W = 4;
  localparam int IMP_PERIOD_CYC = 1024;
  localparam int IMP_CNT_W = 16;
  localparam int IMP_W = 5;
  localparam logic [IMP_W-1:0] IMP_RESET = 5'h10;
  localparam logic [IMP_W-1:0] IMP_MAX = 5'h1F;
  localparam logic [IMP_W-1:0] IMP_MIN = 5'h00;
  typedef enum logic [2:0] {
    B4SIO_DESEL = 3'h1,
    B4SIO_READ = 3'h2,
    B4SIO_WRITE = 3'h4
  } b4sio_op_t;
endpackage

// ### core/b4sio_zq.sv
/*
  Periodic output impedance tracker.
  Assumes an external comparator reports whether drive is too weak.
*/
`timescale 1ns/1ps
module b4sio_zq #(
  parameter int PERIOD = b4sio_pkg::IMP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reference comparison
  input wire logic too_weak,
  // Driver setting
  output logic [b4sio_pkg::IMP_W-1:0] setting
);
  import b4sio_pkg::*;
  logic [IMP_CNT_W-1:0] cnt_q, cnt_d;
  logic [IMP_W-1:0] set_q, set_d;
  logic eval;

  assign eval = (cnt_q == IMP_CNT_W'(PERIOD - 1));

  always_comb begin
    cnt_d = eval ? '0 : cnt_q + IMP_CNT_W'(1);
    set_d = set_q;
    // One step only, so a noisy reading cannot swing the drivers
    if (eval && too_weak && set_q != IMP_MAX) begin
      set_d = set_q + IMP_W'(1);
    end else if (eval && !too_weak && set_q != IMP_MIN) begin
      set_d = set_q - IMP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      set_q <= IMP_RESET;
    end else begin
      cnt_q <= cnt_d;
      set_q <= set_d;
    end
  end

  assign setting = set_q;
endmodule // b4sio_zq

// ### dv/b4sio_clkgen.sv
/*
  Controller-side clock source for the memory core.
  Assumes the bench times strobes and data from the reported phase.
*/
`timescale 1ns/1ps
module b4sio_clkgen (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Clock gate
  input wire logic run,
  // Device clock pins
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  // Phase in one input period
  output logic [1:0] ph
);
  // Output clocks tied high
  assign c = 1'b1;
  assign c_n = 1'b1;
  // Four system cycles a period keep every rise visible to the sampler
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      k <= 1'b0;
      k_n <= 1'b0;
    end else if (run) begin
      ph <= ph + 2'h1;
      k <= (ph == 2'h3);
      k_n <= (ph == 2'h1);
    end else begin
      k <= 1'b0;
      k_n <= 1'b0;
    end
  end
endmodule // b4sio_clkgen

// ### dv/b4sio_core_bench.sv
/*
  Self-checking bench for the memory core.
  Assumes output clocks tied high and four MCLK cycles per input period.
*/
`timescale 1ns/1ps
module b4sio_core_bench;
  import b4sio_pkg::*;
  localparam logic [3:0][17:0] P = {18'h2_BCDE, 18'h1_2345, 18'h0_0F0F, 18'h3_C3A5};
  localparam logic [3:0][17:0] N = ~P;
  localparam logic [3:0][17:0] E = {{N[3][17:9], P[3][8:0]}, N[2], {N[1][17:9], P[1][8:0]},
    {P[0][17:9], N[0][8:0]}};
  logic MCLK, RST_N, K, K_N, C, C_N, READ_N, WRITE_N, Q_OE_N, DLL_ENABLE, DLL_LOCKED;
  logic IMPEDANCE_REF_WEAK, run, chk_b;
  logic [1:0] ph, LANE_MASK_N;
  logic [3:0] LINE_INDEX;
  logic [17:0] D, Q, exp_b;
  logic [IMP_W-1:0] DRV_SETTING;
  int num_errors, checks_done;
  b4sio_core #(.IMP_PERIOD(8)) u_b4sio_core (.MCLK(MCLK), .RST_N(RST_N), .K(K), .K_N(K_N),
    .C(C), .C_N(C_N), .READ_N(READ_N), .WRITE_N(WRITE_N), .LINE_INDEX(LINE_INDEX), .D(D),
    .LANE_MASK_N(LANE_MASK_N), .Q(Q), .Q_OE_N(Q_OE_N), .DLL_ENABLE(DLL_ENABLE),
    .DLL_LOCKED(DLL_LOCKED), .IMPEDANCE_REF_WEAK(IMPEDANCE_REF_WEAK),
    .DRV_SETTING(DRV_SETTING));
  b4sio_clkgen u_b4sio_clkgen (.mclk(MCLK), .rst_n(RST_N), .run(run), .k(K), .k_n(K_N),
    .c(C), .c_n(C_N), .ph(ph));
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One input period: command plus the two beats riding on it
  task automatic period(input logic rn, wn, input logic [3:0] a, input logic [17:0] da,
      input logic [1:0] ma, input logic [17:0] db, input logic [1:0] mb,
      input logic [17:0] qa, qb, input logic chk);
    @(negedge MCLK iff ph == 2'h3);
    if (chk_b) check(Q, exp_b);
    READ_N <= rn;
    WRITE_N <= wn;
    LINE_INDEX <= a;
    D <= da;
    LANE_MASK_N <= ma;
    @(negedge MCLK iff ph == 2'h1);
    if (chk) check(Q, qa);
    check(18'(Q_OE_N), 18'(!chk));
    D <= db;
    LANE_MASK_N <= mb;
    exp_b = qb;
    chk_b = chk;
  endtask
  task automatic wr(input logic [3:0] a);
    period(1'b1, 1'b0, a, 18'h3_FFFF, 2'h3, 18'h0_0000, 2'h3, 18'h0_0000, 18'h0_0000, 1'b0);
  endtask
  // First command, then a second one at line 6, then the read beats
  task automatic rd(input logic rn1, wn1, rn2, input logic [3:0] a,
      input logic [3:0][17:0] d, input logic [7:0] m, input logic [3:0][17:0] e,
      input logic c);
    period(rn1, wn1, a, d[0], m[1:0], d[1], m[3:2], 18'h0_0000, 18'h0_0000, 1'b0);
    period(rn2, 1'b1, 4'h6, d[2], m[5:4], d[3], m[7:6], e[0], e[1], c);
    period(1'b1, 1'b1, 4'hF, 18'h3_FFFF, 2'h3, 18'h0_0000, 2'h3, e[2], e[3], c);
    period(1'b1, 1'b1, 4'hF, 18'h0_0000, 2'h3, 18'h3_FFFF, 2'h3, 18'h0_0000, 18'h0_0000, 1'b0);
  endtask
  task automatic s_dll();
    run <= 1'b1;
    repeat (16) @(negedge MCLK);
    DLL_ENABLE <= 1'b1;
    repeat (1000) @(negedge MCLK iff ph == 2'h3);
    check(18'(DLL_LOCKED), 18'h0_0000);
    repeat (40) @(negedge MCLK iff ph == 2'h3);
    check(18'(DLL_LOCKED), 18'h0_0001);
    run <= 1'b0;
    repeat (5) @(negedge MCLK);
    check(18'(DLL_LOCKED), 18'h0_0000);
    run <= 1'b1;
    DLL_ENABLE <= 1'b0;
    @(negedge MCLK);
    check(18'(DLL_LOCKED), 18'h0_0000);
    DLL_ENABLE <= 1'b1;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // Whole run is near 5000 cycles
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  initial begin
    {RST_N, run, chk_b, DLL_ENABLE, LINE_INDEX} = 8'h00;
    {READ_N, WRITE_N, IMPEDANCE_REF_WEAK, LANE_MASK_N} = 5'h1F;
    D = 18'h0_0000;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(negedge MCLK);
    check(18'(DRV_SETTING), 18'h0_0010);
    RST_N = 1'b1;
    s_dll();
    check(18'(DRV_SETTING), 18'h0_001F);
    IMPEDANCE_REF_WEAK <= 1'b0;
    repeat (320) @(negedge MCLK);
    check(18'(DRV_SETTING), 18'h0_0000);
    wr(4'h3);
    rd(1'b0, 1'b1, 1'b1, 4'h3, P, 8'h00, P, 1'b1);
    wr(4'h3);
    rd(1'b0, 1'b1, 1'b1, 4'h3, N, 8'h46, E, 1'b1);
    wr(4'h3);
    rd(1'b0, 1'b1, 1'b1, 4'h3, P, 8'hFF, E, 1'b1);
    rd(1'b0, 1'b1, 1'b0, 4'h3, P, 8'hFF, E, 1'b1);
    wr(4'h7);
    rd(1'b1, 1'b0, 1'b1, 4'h3, N, 8'h00, E, 1'b0);
    rd(1'b0, 1'b1, 1'b1, 4'h7, P, 8'hFF, N, 1'b1);
    rd(1'b0, 1'b1, 1'b1, 4'h3, P, 8'hFF, E, 1'b1);
    test_done();
  end
endmodule // b4sio_core_bench

// ### dv/b4sio_core_properties.sv
/*
  Pin-level assertions for the memory core.
  Assumes output clocks tied high, so input clock rises fire the outputs.
*/
`timescale 1ns/1ps
module b4sio_chk #(
  parameter int DW = 18
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Command pins
  input wire logic K,
  input wire logic K_N,
  input wire logic READ_N,
  input wire logic WRITE_N,
  // Outputs and status
  input wire logic [DW-1:0] Q,
  input wire logic Q_OE_N,
  input wire logic DLL_ENABLE,
  input wire logic DLL_LOCKED,
  input wire logic IMPEDANCE_REF_WEAK,
  input wire logic [b4sio_pkg::IMP_W-1:0] DRV_SETTING
);
  import b4sio_pkg::*;
  logic k_q, kb_q, lrd_q, lwr_q, pend_q, act_q;
  logic k_rise, kb_rise, edge_any, rd_take, lrd_d, lwr_d, pend_d, act_d;
  // Own command decode, so a slip in the core's decode shows up
  always_comb begin
    k_rise = K & ~k_q;
    kb_rise = K_N & ~kb_q;
    edge_any = k_rise | kb_rise;
    rd_take = k_rise & ~READ_N & ~lrd_q;
    lrd_d = k_rise ? rd_take : lrd_q;
    lwr_d = k_rise ? (~rd_take & ~WRITE_N & ~lwr_q) : lwr_q;
    pend_d = k_rise ? rd_take : pend_q;
    act_d = k_rise ? pend_q : act_q;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      {k_q, kb_q, lrd_q, lwr_q, pend_q, act_q} <= 6'h00;
    end else begin
      {k_q, kb_q, lrd_q, lwr_q, pend_q, act_q} <= {K, K_N, lrd_d, lwr_d, pend_d, act_d};
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  rd_launch_a: assert property (k_rise && pend_q |-> ##2 !Q_OE_N)
    else $error("read burst not driven");
  oe_float_a: assert property (k_rise && !pend_q && !act_q |-> ##2 Q_OE_N)
    else $error("outputs not floated");
  oe_edge_a: assert property ($changed(Q_OE_N) |-> $past(k_rise))
    else $error("enable moved off a clock rise");
  wr_float_a: assert property (k_rise && !WRITE_N && READ_N && !lwr_q && !pend_q && !act_q
    |-> ##2 Q_OE_N)
    else $error("outputs driven after a write");
  q_edge_a: assert property ($changed(Q) |-> $past(edge_any))
    else $error("data moved off an output edge");
  dll_off_a: assert property (!DLL_ENABLE |-> !DLL_LOCKED)
    else $error("locked while disabled");
  dll_stall_a: assert property ((!edge_any) [*4] |-> !DLL_LOCKED)
    else $error("locked with clocks stopped");
  dll_early_a: assert property ($rose(DLL_ENABLE) |=> (!DLL_LOCKED) [*8])
    else $error("locked too soon");
  imp_step_a: assert property ($changed(DRV_SETTING) |-> DRV_SETTING ==
    ($past(IMPEDANCE_REF_WEAK) ? $past(DRV_SETTING) + 5'h01 : $past(DRV_SETTING) - 5'h01))
    else $error("impedance step wrong");
endmodule // b4sio_chk
bind b4sio_core b4sio_chk #(.DW(DW)) u_b4sio_chk (.MCLK(MCLK), .RST_N(RST_N), .K(K),
  .K_N(K_N), .READ_N(READ_N), .WRITE_N(WRITE_N), .Q(Q), .Q_OE_N(Q_OE_N),
  .DLL_ENABLE(DLL_ENABLE), .DLL_LOCKED(DLL_LOCKED),
  .IMPEDANCE_REF_WEAK(IMPEDANCE_REF_WEAK), .DRV_SETTING(DRV_SETTING));
